/* common/protect_pkg.sv */
// Purpose: shared constants and types of the memory access protection block
// Assumes: byte addresses on the register bus, one aligned 32-bit word per register
// Notes:   region bounds are kept at 4-byte granularity
package protect_pkg;
  localparam int          CORE_REGIONS = 16;
  localparam int          BUS_REGIONS  = 4;
  localparam int          ADDR_W       = 32;
  localparam int          DATA_W       = 32;
  localparam int          REG_ADDR_W   = 10;
  localparam int          CFG_W        = 8;

  // register map: addr[9:8] block, addr[7:4] region, addr[3:2] register
  localparam logic [1:0]  BLK_CORE     = 2'h0;
  localparam logic [1:0]  BLK_BUS      = 2'h1;
  localparam logic [1:0]  BLK_CTRL     = 2'h2;
  localparam logic [1:0]  REG_BASE     = 2'h0;
  localparam logic [1:0]  REG_LIMIT    = 2'h1;
  localparam logic [1:0]  REG_CFG      = 2'h2;
  localparam logic [3:0]  CTRL_ROW     = 4'h0;
  localparam logic [1:0]  REG_STATUS   = 2'h0;
  localparam logic [1:0]  REG_MASK     = 2'h1;
  localparam logic [1:0]  REG_FAULT    = 2'h2;

  // configuration fields
  localparam int          CFG_R        = 0;
  localparam int          CFG_WR       = 1;
  localparam int          CFG_X        = 2;
  localparam int          CFG_L        = 7;

  // status and mask fields
  localparam int          EVT_W        = 2;
  localparam int          EVT_CORE     = 0;
  localparam int          EVT_BUS      = 1;

  // reset values
  localparam logic [29:0] BOUND_RST    = 30'h0;
  localparam logic [7:0]  CFG_RST      = 8'h00;
  localparam logic [1:0]  EVT_RST      = 2'h0;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [1:0] {
    ACC_READ  = 2'h0,
    ACC_WRITE = 2'h1,
    ACC_EXEC  = 2'h2
  } access_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_WFWD  = 3'h1,
    ST_WRESP = 3'h2,
    ST_RFWD  = 3'h3,
    ST_RRESP = 3'h4
  } axi_state_t;
endpackage : protect_pkg

/* logic/memory_access_protection.sv */
// Purpose: per-core region guard plus bus-side guard for one non-core AXI initiator
// Assumes: AXI4-Lite single beats from the initiator, all inputs on CLK_SYS
// Notes:   one bus guard instance is placed per non-core initiator
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - sixteen core regions, each with its own bounds and configuration.
// - bounds kept in 4-byte units, so a region may be one word.
// - read, write and execute bits gate matching accesses of each kind.
// - overlapping bounds are stored as written, never rejected.
// - writes to a locked core region's bounds or configuration are dropped.
// - only reset clears a core region's lock bit; bus region config, bit 7 included, stays writable.
// - this guard sits in front of each non-core initiator.
// - the initiator reaches memory only via the M_ port of this guard.
// - bus regions with their own read and write privileges.
// - after reset all bus regions deny every access.
// - each AXI transaction is checked and only permitted ones pass.
// - denied transactions get SLVERR; the initiator must accept it.
module memory_access_protection
  import protect_pkg::*;
(
  // clock and reset
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESET,
  // register bus (Avalon-MM slave)
  input  wire logic [REG_ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [DATA_W-1:0]     AVS_WRITEDATA,
  input  wire logic [3:0]            AVS_BYTEENABLE,
  output logic [DATA_W-1:0]          AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  // interrupt
  output logic                       IRQ,
  // core access check
  input  wire logic                  CORE_REQ,
  input  wire logic [ADDR_W-1:0]     CORE_ADDR,
  input  wire logic [1:0]            CORE_KIND,
  output logic                       CORE_DONE,
  output logic                       CORE_ALLOW,
  output logic                       CORE_HIT,
  output logic [3:0]                 CORE_REGION,
  // AXI4-Lite from the initiator
  input  wire logic                  S_AWVALID,
  input  wire logic [ADDR_W-1:0]     S_AWADDR,
  output logic                       S_AWREADY,
  input  wire logic                  S_WVALID,
  input  wire logic [DATA_W-1:0]     S_WDATA,
  input  wire logic [3:0]            S_WSTRB,
  output logic                       S_WREADY,
  output logic                       S_BVALID,
  output logic [1:0]                 S_BRESP,
  input  wire logic                  S_BREADY,
  input  wire logic                  S_ARVALID,
  input  wire logic [ADDR_W-1:0]     S_ARADDR,
  output logic                       S_ARREADY,
  output logic                       S_RVALID,
  output logic [DATA_W-1:0]          S_RDATA,
  output logic [1:0]                 S_RRESP,
  input  wire logic                  S_RREADY,
  // AXI4-Lite toward memory
  output logic                       M_AWVALID,
  output logic [ADDR_W-1:0]          M_AWADDR,
  input  wire logic                  M_AWREADY,
  output logic                       M_WVALID,
  output logic [DATA_W-1:0]          M_WDATA,
  output logic [3:0]                 M_WSTRB,
  input  wire logic                  M_WREADY,
  input  wire logic                  M_BVALID,
  input  wire logic [1:0]            M_BRESP,
  output logic                       M_BREADY,
  output logic                       M_ARVALID,
  output logic [ADDR_W-1:0]          M_ARADDR,
  input  wire logic                  M_ARREADY,
  input  wire logic                  M_RVALID,
  input  wire logic [DATA_W-1:0]     M_RDATA,
  input  wire logic [1:0]            M_RRESP,
  output logic                       M_RREADY
);

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [3:0]        be);
    logic [DATA_W-1:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // register storage
  logic [29:0]      core_base_q  [CORE_REGIONS];
  logic [29:0]      core_limit_q [CORE_REGIONS];
  logic [CFG_W-1:0] core_cfg_q   [CORE_REGIONS];
  logic [29:0]      bus_base_q   [BUS_REGIONS];
  logic [29:0]      bus_limit_q  [BUS_REGIONS];
  logic [CFG_W-1:0] bus_cfg_q    [BUS_REGIONS];
  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] mask_q;
  logic [ADDR_W-1:0] fault_addr_q;
  logic             wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic             irq_q;

  // bus decode
  logic [1:0]       blk;
  logic [3:0]       row;
  logic [1:0]       sel;
  logic             wr_go;
  assign blk   = AVS_ADDRESS[9:8];
  assign row   = AVS_ADDRESS[7:4];
  assign sel   = AVS_ADDRESS[3:2];
  assign wr_go = AVS_WRITE && !wait_q;

  // one wait cycle, then a single cycle with waitrequest low
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      wait_q <= 1'b1;
    end else if ((AVS_READ || AVS_WRITE) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // read mux, latched while waitrequest is still high
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (blk)
      BLK_CORE: begin
        case (sel)
          REG_BASE:  rd_mux = {core_base_q[row], 2'h0};
          REG_LIMIT: rd_mux = {core_limit_q[row], 2'h0};
          REG_CFG:   rd_mux = {24'h0, core_cfg_q[row]};
          default:   rd_mux = '0;
        endcase
      end
      BLK_BUS: begin
        if (row < 4'(BUS_REGIONS)) begin
          case (sel)
            REG_BASE:  rd_mux = {bus_base_q[row[1:0]], 2'h0};
            REG_LIMIT: rd_mux = {bus_limit_q[row[1:0]], 2'h0};
            REG_CFG:   rd_mux = {24'h0, bus_cfg_q[row[1:0]]};
            default:   rd_mux = '0;
          endcase
        end
      end
      BLK_CTRL: begin
        if (row == CTRL_ROW) begin
          case (sel)
            REG_STATUS: rd_mux = {30'h0, status_q};
            REG_MASK:   rd_mux = {30'h0, mask_q};
            REG_FAULT:  rd_mux = fault_addr_q;
            default:    rd_mux = '0;
          endcase
        end
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rdata_q <= '0;
    end else if (AVS_READ && wait_q) begin
      rdata_q <= rd_mux;
    end
  end

  // core region registers; bounds stored unchanged even when overlapping
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      for (int i = 0; i < CORE_REGIONS; i++) begin
        core_base_q[i]  <= BOUND_RST;
        core_limit_q[i] <= BOUND_RST;
        core_cfg_q[i]   <= CFG_RST;
      end
    end else if (wr_go && blk == BLK_CORE && !core_cfg_q[row][CFG_L]) begin
      case (sel)
        REG_BASE:  core_base_q[row]  <= 30'(merge({core_base_q[row], 2'h0}, AVS_WRITEDATA, AVS_BYTEENABLE) >> 2);
        REG_LIMIT: core_limit_q[row] <= 30'(merge({core_limit_q[row], 2'h0}, AVS_WRITEDATA, AVS_BYTEENABLE) >> 2);
        REG_CFG:   core_cfg_q[row]   <= AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : core_cfg_q[row];
        default:   core_cfg_q[row]   <= core_cfg_q[row];
      endcase
    end
  end

  // bus region registers, all cleared to deny at reset
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      for (int j = 0; j < BUS_REGIONS; j++) begin
        bus_base_q[j]  <= BOUND_RST;
        bus_limit_q[j] <= BOUND_RST;
        bus_cfg_q[j]   <= CFG_RST;
      end
    end else if (wr_go && blk == BLK_BUS && row < 4'(BUS_REGIONS)) begin
      case (sel)
        REG_BASE:  bus_base_q[row[1:0]]  <= 30'(merge({bus_base_q[row[1:0]], 2'h0}, AVS_WRITEDATA,
                                                     AVS_BYTEENABLE) >> 2);
        REG_LIMIT: bus_limit_q[row[1:0]] <= 30'(merge({bus_limit_q[row[1:0]], 2'h0}, AVS_WRITEDATA,
                                                     AVS_BYTEENABLE) >> 2);
        REG_CFG:   bus_cfg_q[row[1:0]]   <= AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : bus_cfg_q[row[1:0]];
        default:   bus_cfg_q[row[1:0]]   <= bus_cfg_q[row[1:0]];
      endcase
    end
  end

  // core region match, word granular
  logic [CORE_REGIONS-1:0] core_hit;
  for (genvar i = 0; i < CORE_REGIONS; i++) begin : g_core
    assign core_hit[i] = CORE_ADDR[31:2] >= core_base_q[i] && CORE_ADDR[31:2] <= core_limit_q[i];
  end

  logic       c_hit;
  logic [3:0] c_idx;
  logic       c_allow;
  always_comb begin
    c_hit   = 1'b0;
    c_idx   = 4'h0;
    c_allow = 1'b0;
    for (int i = CORE_REGIONS - 1; i >= 0; i--) begin
      if (core_hit[i]) begin
        c_hit = 1'b1;
        c_idx = 4'(i);
      end
    end
    if (c_hit) begin
      case (access_kind_t'(CORE_KIND))
        ACC_READ:  c_allow = core_cfg_q[c_idx][CFG_R];
        ACC_WRITE: c_allow = core_cfg_q[c_idx][CFG_WR];
        ACC_EXEC:  c_allow = core_cfg_q[c_idx][CFG_X];
        default:   c_allow = 1'b0;
      endcase
    end
  end

  // check result one cycle after the request, against current registers
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      CORE_DONE   <= 1'b0;
      CORE_ALLOW  <= 1'b0;
      CORE_HIT    <= 1'b0;
      CORE_REGION <= 4'h0;
    end else begin
      CORE_DONE   <= CORE_REQ;
      CORE_ALLOW  <= CORE_REQ && c_allow;
      CORE_HIT    <= CORE_REQ && c_hit;
      CORE_REGION <= CORE_REQ ? c_idx : 4'h0;
    end
  end

  // bus region check: any matching region with the privilege grants
  logic [BUS_REGIONS-1:0] bus_w_ok;
  logic [BUS_REGIONS-1:0] bus_r_ok;
  for (genvar j = 0; j < BUS_REGIONS; j++) begin : g_bus
    assign bus_w_ok[j] = bus_cfg_q[j][CFG_WR] && S_AWADDR[31:2] >= bus_base_q[j]
                         && S_AWADDR[31:2] <= bus_limit_q[j];
    assign bus_r_ok[j] = bus_cfg_q[j][CFG_R] && S_ARADDR[31:2] >= bus_base_q[j]
                         && S_ARADDR[31:2] <= bus_limit_q[j];
  end

  // AXI transaction engine, one transaction at a time, writes first
  axi_state_t state_q;
  logic       bus_fault;
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_q   <= ST_IDLE;
      S_AWREADY <= 1'b0;
      S_WREADY  <= 1'b0;
      S_BVALID  <= 1'b0;
      S_BRESP   <= RESP_OKAY;
      S_ARREADY <= 1'b0;
      S_RVALID  <= 1'b0;
      S_RDATA   <= '0;
      S_RRESP   <= RESP_OKAY;
      M_AWVALID <= 1'b0;
      M_AWADDR  <= '0;
      M_WVALID  <= 1'b0;
      M_WDATA   <= '0;
      M_WSTRB   <= 4'h0;
      M_BREADY  <= 1'b0;
      M_ARVALID <= 1'b0;
      M_ARADDR  <= '0;
      M_RREADY  <= 1'b0;
      bus_fault <= 1'b0;
    end else begin
      S_AWREADY <= 1'b0;
      S_WREADY  <= 1'b0;
      S_ARREADY <= 1'b0;
      bus_fault <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (S_AWVALID && S_WVALID) begin
            S_AWREADY <= 1'b1;
            S_WREADY  <= 1'b1;
            if (|bus_w_ok) begin
              M_AWVALID <= 1'b1;
              M_AWADDR  <= S_AWADDR;
              M_WVALID  <= 1'b1;
              M_WDATA   <= S_WDATA;
              M_WSTRB   <= S_WSTRB;
              M_BREADY  <= 1'b1;
              state_q   <= ST_WFWD;
            end else begin
              S_BVALID  <= 1'b1;
              S_BRESP   <= RESP_SLVERR;
              bus_fault <= 1'b1;
              state_q   <= ST_WRESP;
            end
          end else if (S_ARVALID) begin
            S_ARREADY <= 1'b1;
            if (|bus_r_ok) begin
              M_ARVALID <= 1'b1;
              M_ARADDR  <= S_ARADDR;
              M_RREADY  <= 1'b1;
              state_q   <= ST_RFWD;
            end else begin
              S_RVALID  <= 1'b1;
              S_RDATA   <= '0;
              S_RRESP   <= RESP_SLVERR;
              bus_fault <= 1'b1;
              state_q   <= ST_RRESP;
            end
          end
        end
        ST_WFWD: begin
          if (M_AWREADY) begin
            M_AWVALID <= 1'b0;
          end
          if (M_WREADY) begin
            M_WVALID <= 1'b0;
          end
          if (M_BVALID) begin
            M_BREADY <= 1'b0;
            S_BVALID <= 1'b1;
            S_BRESP  <= M_BRESP;
            state_q  <= ST_WRESP;
          end
        end
        ST_WRESP: begin
          if (S_BREADY) begin
            S_BVALID <= 1'b0;
            state_q  <= ST_IDLE;
          end
        end
        ST_RFWD: begin
          if (M_ARREADY) begin
            M_ARVALID <= 1'b0;
          end
          if (M_RVALID) begin
            M_RREADY <= 1'b0;
            S_RVALID <= 1'b1;
            S_RDATA  <= M_RDATA;
            S_RRESP  <= M_RRESP;
            state_q  <= ST_RRESP;
          end
        end
        ST_RRESP: begin
          if (S_RREADY) begin
            S_RVALID <= 1'b0;
            state_q  <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // address of the last denied bus transaction
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      fault_addr_q <= '0;
    end else if (state_q == ST_IDLE && S_AWVALID && S_WVALID && !(|bus_w_ok)) begin
      fault_addr_q <= S_AWADDR;
    end else if (state_q == ST_IDLE && !(S_AWVALID && S_WVALID) && S_ARVALID && !(|bus_r_ok)) begin
      fault_addr_q <= S_ARADDR;
    end
  end

  // sticky events, write one to clear, a new event wins over the clear
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;
  assign evt_set = {bus_fault, CORE_DONE && !CORE_ALLOW};
  assign evt_clr = (wr_go && blk == BLK_CTRL && row == CTRL_ROW && sel == REG_STATUS && AVS_BYTEENABLE[0])
                   ? AVS_WRITEDATA[EVT_W-1:0] : EVT_RST;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      status_q <= EVT_RST;
      mask_q   <= EVT_RST;
      irq_q    <= 1'b0;
    end else begin
      status_q <= (status_q & ~evt_clr) | evt_set;
      if (wr_go && blk == BLK_CTRL && row == CTRL_ROW && sel == REG_MASK && AVS_BYTEENABLE[0]) begin
        mask_q <= AVS_WRITEDATA[EVT_W-1:0];
      end
      irq_q <= |(((status_q & ~evt_clr) | evt_set) & mask_q);
    end
  end

  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign IRQ             = irq_q;

endmodule : memory_access_protection

`default_nettype wire

/* sim/mem_target_model.sv */
// Purpose: memory target answering the guard's forwarded AXI4-Lite beats
// Assumes: one transaction at a time, slow adds three wait cycles
// Notes:   read data is the inverted address; idle data toggles
`timescale 1ns/1ps
`default_nettype none
module mem_target_model
  import protect_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  // pace select
  input  wire logic        slow,
  // write side
  input  wire logic        M_AWVALID,
  output logic             M_AWREADY,
  input  wire logic        M_WVALID,
  input  wire logic [31:0] M_WDATA,
  output logic             M_WREADY,
  output logic             M_BVALID,
  output logic [1:0]       M_BRESP,
  input  wire logic        M_BREADY,
  // read side
  input  wire logic        M_ARVALID,
  input  wire logic [31:0] M_ARADDR,
  output logic             M_ARREADY,
  output logic             M_RVALID,
  output logic [31:0]      M_RDATA,
  output logic [1:0]       M_RRESP,
  input  wire logic        M_RREADY,
  // last word stored
  output logic [31:0]      last_wdata
);
  logic [1:0]  wait_q;
  logic [31:0] raddr_q;
  logic        busy;
  assign busy = M_AWREADY | M_ARREADY | M_BVALID | M_RVALID;
  always_ff @(posedge CLK_SYS) begin
    M_AWREADY <= 1'b0;
    M_WREADY  <= 1'b0;
    M_ARREADY <= 1'b0;
    M_BRESP   <= RESP_OKAY;
    M_RRESP   <= RESP_OKAY;
    if (RESET) begin
      wait_q     <= 2'h0;
      M_BVALID   <= 1'b0;
      M_RVALID   <= 1'b0;
      M_RDATA    <= 32'h5A5A5A5A;
      raddr_q    <= 32'h0;
      last_wdata <= 32'h0;
    end else begin
      if (M_BVALID && M_BREADY)
        M_BVALID <= 1'b0;
      // released data lines do not keep the last value
      if (M_RVALID && M_RREADY) begin
        M_RVALID <= 1'b0;
        M_RDATA  <= ~M_RDATA;
      end
      if (M_AWREADY)
        M_BVALID <= 1'b1;
      if (M_ARREADY) begin
        M_RVALID <= 1'b1;
        M_RDATA  <= ~raddr_q;
      end
      if (!busy && ((M_AWVALID && M_WVALID) || M_ARVALID)) begin
        if (slow && wait_q != 2'h3) begin
          wait_q <= wait_q + 2'h1;
        end else if (M_AWVALID && M_WVALID) begin
          wait_q     <= 2'h0;
          M_AWREADY  <= 1'b1;
          M_WREADY   <= 1'b1;
          last_wdata <= M_WDATA;
        end else begin
          wait_q    <= 2'h0;
          M_ARREADY <= 1'b1;
          raddr_q   <= M_ARADDR;
        end
      end
    end
  end
endmodule : mem_target_model
`default_nettype wire

/* sim/protect_monitor.sv */
// Purpose: port-level checks of the memory access protection block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound to every instance of memory_access_protection
`timescale 1ns/1ps
`default_nettype none
module protect_monitor
  import protect_pkg::*;
(
  // clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  // register bus
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic        AVS_WAITREQUEST,
  // core check
  input wire logic        CORE_REQ,
  input wire logic        CORE_DONE,
  input wire logic        CORE_ALLOW,
  input wire logic        CORE_HIT,
  input wire logic [3:0]  CORE_REGION,
  // initiator side
  input wire logic        S_AWREADY,
  input wire logic        S_BVALID,
  input wire logic [1:0]  S_BRESP,
  input wire logic        S_BREADY,
  input wire logic        S_ARREADY,
  input wire logic        S_RVALID,
  input wire logic [31:0] S_RDATA,
  input wire logic [1:0]  S_RRESP,
  // memory side
  input wire logic        M_AWVALID,
  input wire logic        M_WVALID,
  input wire logic        M_ARVALID,
  input wire logic        M_ARREADY,
  input wire logic [31:0] M_ARADDR
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  property p_wait_ans;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_wait_ans: assert property (p_wait_ans)
    else $error("register access not answered after one wait");
  property p_wait_one;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");
  property p_core_done;
    CORE_DONE == $past(CORE_REQ);
  endproperty
  a_core_done: assert property (p_core_done)
    else $error("core check answer not one cycle after request");
  property p_nohit;
    CORE_DONE && !CORE_HIT |-> !CORE_ALLOW && CORE_REGION == 4'h0;
  endproperty
  a_nohit: assert property (p_nohit)
    else $error("unmatched core access allowed or region nonzero");
  property p_deny_wr;
    S_AWREADY && S_BVALID |-> S_BRESP == RESP_SLVERR && !M_AWVALID && !M_WVALID;
  endproperty
  a_deny_wr: assert property (p_deny_wr)
    else $error("denied write forwarded or not faulted");
  property p_deny_rd;
    S_ARREADY && S_RVALID |-> S_RRESP == RESP_SLVERR && S_RDATA == 32'h0 && !M_ARVALID;
  endproperty
  a_deny_rd: assert property (p_deny_rd)
    else $error("denied read forwarded or data nonzero");
  property p_b_hold;
    S_BVALID && !S_BREADY |=> S_BVALID && $stable(S_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped before accepted");
  property p_b_done;
    S_BVALID && S_BREADY |=> !S_BVALID;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("write response stays after acceptance");
  property p_fwd_hold;
    M_ARVALID && !M_ARREADY |=> M_ARVALID && $stable(M_ARADDR);
  endproperty
  a_fwd_hold: assert property (p_fwd_hold)
    else $error("forwarded read address not held");
endmodule : protect_monitor

bind memory_access_protection protect_monitor u_monitor (
  .CLK_SYS, .RESET, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST,
  .CORE_REQ, .CORE_DONE, .CORE_ALLOW, .CORE_HIT, .CORE_REGION,
  .S_AWREADY, .S_BVALID, .S_BRESP, .S_BREADY, .S_ARREADY, .S_RVALID, .S_RDATA, .S_RRESP,
  .M_AWVALID, .M_WVALID, .M_ARVALID, .M_ARREADY, .M_ARADDR
);
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: self-checking bench of the memory access protection block
// Assumes: memory side answered by mem_target_model
// Notes:   every scenario is its own task
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import protect_pkg::*;
;
  logic        CLK_SYS, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ, slow;
  logic [9:0]  AVS_ADDRESS;
  logic [3:0]  AVS_BYTEENABLE, S_WSTRB, M_WSTRB, CORE_REGION;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, CORE_ADDR, S_AWADDR, S_WDATA, S_ARADDR, S_RDATA;
  logic [31:0] M_AWADDR, M_WDATA, M_ARADDR, M_RDATA, last_wdata, rd, resp;
  logic        CORE_REQ, CORE_DONE, CORE_ALLOW, CORE_HIT, S_AWVALID, S_AWREADY, S_WVALID, S_WREADY;
  logic        S_BVALID, S_BREADY, S_ARVALID, S_ARREADY, S_RVALID, S_RREADY, M_AWVALID, M_AWREADY;
  logic        M_WVALID, M_WREADY, M_BVALID, M_BREADY, M_ARVALID, M_ARREADY, M_RVALID, M_RREADY;
  logic [1:0]  CORE_KIND, S_BRESP, S_RRESP, M_BRESP, M_RRESP;
  int          mismatches, samples_checked, cycles;

  memory_access_protection dut (.*);
  mem_target_model u_mem (.*);

  initial begin
    CLK_SYS = 1'b0;
    forever #12.5 CLK_SYS = ~CLK_SYS;
  end

  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic av(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    AVS_ADDRESS   <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE     <= wr;
    AVS_READ      <= !wr;
    do @(posedge CLK_SYS); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
  endtask : av

  task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
    av(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // exp packs done, allow, hit and region
  task automatic core(input logic [31:0] a, input logic [1:0] k, input logic [6:0] exp);
    @(posedge CLK_SYS);
    CORE_REQ  <= 1'b1;
    CORE_ADDR <= a;
    CORE_KIND <= k;
    @(posedge CLK_SYS);
    CORE_REQ <= 1'b0;
    @(posedge CLK_SYS);
    chk({25'h0, CORE_DONE, CORE_ALLOW, CORE_HIT, CORE_REGION}, {25'h0, exp});
  endtask : core

  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    S_AWVALID <= 1'b1;
    S_WVALID  <= 1'b1;
    S_AWADDR  <= a;
    S_WDATA   <= d;
    do @(posedge CLK_SYS); while (S_AWREADY !== 1'b1);
    chk({31'h0, S_WREADY}, 32'h1);
    S_AWVALID <= 1'b0;
    S_WVALID  <= 1'b0;
    while (S_BVALID !== 1'b1) @(posedge CLK_SYS);
    resp = {30'h0, S_BRESP};
    S_BREADY <= 1'b1;
    @(posedge CLK_SYS);
    S_BREADY <= 1'b0;
  endtask : axw

  task automatic axr(input logic [31:0] a);
    @(posedge CLK_SYS);
    S_ARVALID <= 1'b1;
    S_ARADDR  <= a;
    S_RREADY  <= 1'b1;
    do @(posedge CLK_SYS); while (S_ARREADY !== 1'b1);
    S_ARVALID <= 1'b0;
    while (S_RVALID !== 1'b1) @(posedge CLK_SYS);
    rd = S_RDATA;
    resp = {30'h0, S_RRESP};
    S_RREADY <= 1'b0;
  endtask : axr

  task automatic t_reset();
    logic [9:0] a[5] = '{10'h008, 10'h0F8, 10'h108, 10'h200, 10'h30C};
    foreach (a[i]) rdchk(a[i], 32'h0);
  endtask : t_reset

  task automatic t_core();
    av(1'b1, 10'h0F0, 32'h1000);
    av(1'b1, 10'h0F4, 32'h1FFC);
    av(1'b1, 10'h030, 32'h1004);
    av(1'b1, 10'h034, 32'h1007);
    av(1'b1, 10'h038, 32'h2);
    rdchk(10'h034, 32'h1004);
    for (int k = 0; k < 3; k++) begin
      av(1'b1, 10'h0F8, 32'h1 << k);
      for (int j = 0; j < 4; j++) core(32'h1FFC, 2'(j), {1'b1, j == k, 5'h1F});
    end
    av(1'b1, 10'h0F8, 32'h7);
    core(32'h1004, 2'h0, 7'h53);
    core(32'h1004, 2'h1, 7'h73);
    core(32'h1008, 2'h2, 7'h7F);
    core(32'h1000, 2'h0, 7'h7F);
    core(32'h2000, 2'h0, 7'h40);
  endtask : t_core

  task automatic t_lock();
    av(1'b1, 10'h038, 32'h82);
    av(1'b1, 10'h038, 32'h1);
    av(1'b1, 10'h030, 32'h0);
    rdchk(10'h038, 32'h82);
    rdchk(10'h030, 32'h1004);
    core(32'h1004, 2'h1, 7'h73);
    av(1'b1, 10'h038, 32'h0);
    rdchk(10'h038, 32'h82);
    @(posedge CLK_SYS);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RESET <= 1'b0;
    rdchk(10'h038, 32'h0);
    AVS_BYTEENABLE <= 4'h1;
    av(1'b1, 10'h030, 32'hFFFFFF08);
    AVS_BYTEENABLE <= 4'hF;
    rdchk(10'h030, 32'h8);
  endtask : t_lock

  task automatic t_irq();
    core(32'h40, 2'h0, 7'h40);
    rdchk(10'h200, 32'h1);
    chk({31'h0, IRQ}, 32'h0);
    av(1'b1, 10'h204, 32'h3);
    repeat (2) @(posedge CLK_SYS);
    chk({31'h0, IRQ}, 32'h1);
    av(1'b1, 10'h200, 32'h1);
    repeat (2) @(posedge CLK_SYS);
    chk({31'h0, IRQ}, 32'h0);
  endtask : t_irq

  task automatic t_axi();
    axw(32'h40, 32'h1234);
    chk(resp, 32'(RESP_SLVERR));
    axr(32'h40);
    chk(rd, 32'h0);
    chk(resp, 32'(RESP_SLVERR));
    rdchk(10'h200, 32'h2);
    av(1'b1, 10'h100, 32'h40);
    av(1'b1, 10'h104, 32'h7C);
    av(1'b1, 10'h108, 32'h3);
    axw(32'h7C, 32'hCAFE0001);
    chk(resp, 32'(RESP_OKAY));
    chk(last_wdata, 32'hCAFE0001);
    chk(M_AWADDR, 32'h7C);
    slow <= 1'b1;
    axr(32'h44);
    chk(rd, ~32'h44);
    chk(resp, 32'(RESP_OKAY));
    axr(32'h80);
    chk(resp, 32'(RESP_SLVERR));
    rdchk(10'h208, 32'h80);
    av(1'b1, 10'h108, 32'h1);
    axw(32'h40, 32'h5);
    chk(resp, 32'(RESP_SLVERR));
    rdchk(10'h208, 32'h40);
  endtask : t_axi

  initial begin
    RESET = 1'b1;
    {AVS_READ, AVS_WRITE, CORE_REQ, S_AWVALID, S_WVALID, S_BREADY, S_ARVALID, S_RREADY, slow} = '0;
    {AVS_ADDRESS, AVS_WRITEDATA, CORE_ADDR, CORE_KIND, S_AWADDR, S_WDATA, S_ARADDR} = '0;
    AVS_BYTEENABLE = 4'hF;
    S_WSTRB = 4'hF;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge CLK_SYS);
    RESET <= 1'b0;
    t_reset();
    t_core();
    t_lock();
    t_irq();
    t_axi();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
